// ---- hw/sso_pkg.sv ----
// Purpose: shared constants and types for the safety output restart block
// Assumes: 50 MHz core clock
// Notes:   all times held in their own unit, cycle counts derived here
package sso_pkg;
  localparam int CLK_HZ         = 50_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int SCAN_PERIOD_MS = 30;
  localparam int MIN_SCANS      = 2;
  localparam int MAX_SCANS      = 16;
  localparam int MIN_RESP_MS    = 62;
  localparam int RECOV_MIN_MS   = 200;
  localparam int RECOV_MAX_MS   = 60000;
  localparam int HOLD_MIN_MS    = 500;
  localparam int HOLD_MAX_MS    = 4500;
  localparam int SEC_LAT_MS     = 10;
  localparam int REF_MIN_PER_OBJ = 3;
  localparam int REF_MAX_POINTS = 15;
  localparam int REF_MIN_TOL_MM = 10;
  localparam int TEST_PERIOD_MS = 100;
  localparam int TEST_PULSE_US  = 200;
  localparam int TEST_PULSE_CYC = (CLK_HZ / 1_000_000) * TEST_PULSE_US;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_RECOV   = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_REF_EN  = 8'h0c;
  localparam logic [7:0] OFF_REF_OBJ = 8'h10;
  localparam logic [1:0] REF_TAB_HI  = 2'h1;
  // control and status field positions
  localparam int CTRL_MANUAL   = 0;
  localparam int CTRL_SCANS_LO = 1;
  localparam int CTRL_SEC_LO   = 6;
  localparam int CTRL_REF_ON   = 8;
  localparam int CTRL_FCLR     = 9;
  localparam int STAT_RESP_LO  = 16;
  // reset values
  localparam logic [4:0]  SCANS_RST = 5'h02;
  localparam logic [15:0] RECOV_RST = 16'h00c8;
  typedef enum logic [1:0] {ST_GO, ST_READY, ST_BLOCKED, ST_FAULT} sso_state_e;
  typedef enum logic [1:0] {TP_IDLE, TP_A, TP_B} sso_test_e;
endpackage

// ---- hw/sso_mem_if.sv ----
// Purpose: carrier between controller and reference point store
// Assumes: one write port, two registered read ports
// Notes:   entry = {tolFar, tolNear, distance}
`timescale 1ns/1ps
`default_nettype none
interface sso_mem_if;
  logic        wrEn;
  logic [3:0]  wrIdx;
  logic [31:0] wrData;
  logic [3:0]  rdIdxA;
  logic [31:0] rdDataA;
  logic [3:0]  rdIdxB;
  logic [31:0] rdDataB;
  modport mem  (input wrEn, wrIdx, wrData, rdIdxA, rdIdxB, output rdDataA, rdDataB);
  modport user (output wrEn, wrIdx, wrData, rdIdxA, rdIdxB, input rdDataA, rdDataB);
endinterface
`default_nettype wire

// ---- hw/sso_ref_mem.sv ----
// Purpose: reference point table, fifteen words
// Assumes: same clock as controller
// Notes:   read data registered, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module sso_ref_mem
  import sso_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstN,
  sso_mem_if.mem   port
);
  logic [31:0] entry [REF_MAX_POINTS];

  genvar g;
  generate
    for (g = 0; g < REF_MAX_POINTS; g++)
    begin : gEnt
      always_ff @(posedge core_clk or negedge rstN)
        if (!rstN)
          entry[g] <= 32'h0;
        else if (port.wrEn && port.wrIdx == 4'(g))
          entry[g] <= port.wrData;
    end
  endgenerate

  // index 15 has no storage and reads zero
  always_ff @(posedge core_clk)
  begin
    port.rdDataA <= (port.rdIdxA == 4'hf) ? 32'h0 : entry[port.rdIdxA];
    port.rdDataB <= (port.rdIdxB == 4'hf) ? 32'h0 : entry[port.rdIdxB];
  end
endmodule
`default_nettype wire

// ---- hw/sso_restart_ctrl.sv ----
// Purpose: safety switch output pair with stop, restart interlock and self test
// Assumes: AHB-Lite single word transfers; detection inputs on core_clk
// Notes:   button and readbacks are pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
module sso_restart_ctrl
  import sso_pkg::*;
#(
  parameter int CYC_MS   = CYC_PER_MS,
  parameter int TEST_CYC = TEST_PULSE_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        objDetect,
  input  wire logic        secStop,
  input  wire logic        measValid,
  input  wire logic [3:0]  measIdx,
  input  wire logic [15:0] measDist,
  input  wire logic        restartBtn,
  input  wire logic        readbackA,
  input  wire logic        readbackB,
  output logic             safeOutA,
  output logic             safeOutB,
  output logic             lampOut,
  output logic             faultOut
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rstSync_r;
  logic       rstN;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  assign rstN = rstSync_r[1];

  logic [2:0] pinMeta_r, pinSync_r;
  logic       btnSync, rbA, rbB, btnPrev_r;
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      pinMeta_r <= 3'h0;
      pinSync_r <= 3'h0;
      btnPrev_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= {readbackB, readbackA, restartBtn};
      pinSync_r <= pinMeta_r;
      btnPrev_r <= pinSync_r[0];
    end
  assign btnSync = pinSync_r[0];
  assign rbA     = pinSync_r[1];
  assign rbB     = pinSync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] msDiv_r;
  logic [4:0]  scanMs_r;
  logic        msTick, scanTick;
  assign msTick   = (msDiv_r == 16'(CYC_MS - 1));
  assign scanTick = msTick && (scanMs_r == 5'(SCAN_PERIOD_MS - 1));
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      msDiv_r  <= 16'h0;
      scanMs_r <= 5'h0;
    end
    else
    begin
      msDiv_r <= msTick ? 16'h0 : msDiv_r + 16'h1;
      if (scanTick)
        scanMs_r <= 5'h0;
      else if (msTick)
        scanMs_r <= scanMs_r + 5'h1;
    end

  ////////////////////////////////////////////////////////////////////////////
  logic        manualMode_r, refOn_r;
  logic [4:0]  scans_r, scansEff;
  logic [1:0]  secCnt_r;
  logic [15:0] recov_r, recovEff;
  logic [14:0] refEn_r;
  logic [29:0] refObj_r;
  logic        dWr_r, rdPend_r, rdTab_r, faultClr;
  logic [7:0]  dAddr_r;
  logic [31:0] rdReg_r, status;
  logic        addrPh, ctrlWr;
  sso_mem_if   memBus ();

  // scan count clamped to its range
  assign scansEff = (scans_r < 5'(MIN_SCANS)) ? 5'(MIN_SCANS)
                  : (scans_r > 5'(MAX_SCANS)) ? 5'(MAX_SCANS) : scans_r;
  assign recovEff = (recov_r < 16'(RECOV_MIN_MS)) ? 16'(RECOV_MIN_MS)
                  : (recov_r > 16'(RECOV_MAX_MS)) ? 16'(RECOV_MAX_MS) : recov_r;

  assign addrPh    = hsel && htrans[1] && hready;
  assign ctrlWr    = dWr_r && dAddr_r == OFF_CTRL;
  assign faultClr  = ctrlWr && hwdata[CTRL_FCLR];
  assign hreadyout = !rdPend_r;
  assign hresp     = 1'b0;
  assign hrdata    = rdTab_r ? memBus.rdDataB : rdReg_r;

  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      dWr_r    <= 1'b0;
      dAddr_r  <= 8'h0;
      rdPend_r <= 1'b0;
      rdTab_r  <= 1'b0;
    end
    else
    begin
      dWr_r    <= addrPh && hwrite;
      rdPend_r <= addrPh && !hwrite;
      if (addrPh)
      begin
        dAddr_r <= haddr[7:0];
        rdTab_r <= !hwrite && haddr[7:6] == REF_TAB_HI;
      end
    end

  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      manualMode_r <= 1'b0;
      scans_r      <= SCANS_RST;
      secCnt_r     <= 2'h0;
      refOn_r      <= 1'b0;
      recov_r      <= RECOV_RST;
      refEn_r      <= 15'h0;
      refObj_r     <= 30'h0;
    end
    else if (dWr_r)
    begin
      if (ctrlWr)
      begin
        manualMode_r <= hwdata[CTRL_MANUAL];
        scans_r      <= hwdata[CTRL_SCANS_LO +: 5];
        secCnt_r     <= hwdata[CTRL_SEC_LO +: 2];
        refOn_r      <= hwdata[CTRL_REF_ON];
      end
      if (dAddr_r == OFF_RECOV)
        recov_r <= hwdata[15:0];
      if (dAddr_r == OFF_REF_EN)
        refEn_r <= hwdata[14:0];
      if (dAddr_r == OFF_REF_OBJ)
        refObj_r <= hwdata[29:0];
    end

  // wait state lets the read see a write done just before it
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
      rdReg_r <= 32'h0;
    else if (rdPend_r)
      case (dAddr_r)
        OFF_CTRL:    rdReg_r <= {22'h0, 1'b0, refOn_r, secCnt_r, scans_r, manualMode_r};
        OFF_RECOV:   rdReg_r <= {16'h0, recov_r};
        OFF_STATUS:  rdReg_r <= status;
        OFF_REF_EN:  rdReg_r <= {17'h0, refEn_r};
        OFF_REF_OBJ: rdReg_r <= {2'h0, refObj_r};
        default:     rdReg_r <= 32'h0;
      endcase

  assign memBus.wrEn   = dWr_r && dAddr_r[7:6] == REF_TAB_HI;
  assign memBus.wrIdx  = dAddr_r[5:2];
  assign memBus.wrData = hwdata;
  assign memBus.rdIdxB = dAddr_r[5:2];
  assign memBus.rdIdxA = measIdx;

  sso_ref_mem uMem (
    .core_clk (core_clk),
    .rstN     (rstN),
    .port     (memBus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] detCnt_r;
  logic       zoneOcc_r, detStop;
  // stop needs scansEff consecutive detecting scans
  assign detStop = scanTick && objDetect && (detCnt_r + 5'h1 >= scansEff);
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      detCnt_r  <= 5'h0;
      zoneOcc_r <= 1'b0;
    end
    else if (scanTick)
    begin
      detCnt_r  <= !objDetect ? 5'h0 : detStop ? detCnt_r : detCnt_r + 5'h1;
      zoneOcc_r <= objDetect && (zoneOcc_r || detStop);
    end

  // latency of 10 ms per secondary unit
  logic       secPrev_r, latRun_r, secFire, secRise;
  logic [5:0] latCnt_r;
  assign secRise = secStop && !secPrev_r;
  assign secFire = (secRise && secCnt_r == 2'h0) || (latRun_r && latCnt_r == 6'h0);
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      secPrev_r <= 1'b0;
      latRun_r  <= 1'b0;
      latCnt_r  <= 6'h0;
    end
    else
    begin
      secPrev_r <= secStop;
      if (secRise && secCnt_r != 2'h0 && !latRun_r)
      begin
        latRun_r <= 1'b1;
        latCnt_r <= 6'(SEC_LAT_MS) * {4'h0, secCnt_r};
      end
      else if (secFire)
        latRun_r <= 1'b0;
      else if (latRun_r && msTick)
        latCnt_r <= latCnt_r - 6'h1;
    end

  ////////////////////////////////////////////////////////////////////////////
  logic        measV_r, refDev, refCfgBad, refHit;
  logic [3:0]  measIdx_r;
  logic [15:0] measDist_r;
  logic [16:0] tolN, tolF, refDist;
  logic [3:0]  objHot [REF_MAX_POINTS];
  logic [3:0]  objCnt [4];
  logic [15:0] refEn16;
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      measV_r    <= 1'b0;
      measIdx_r  <= 4'h0;
      measDist_r <= 16'h0;
    end
    else
    begin
      measV_r    <= measValid;
      measIdx_r  <= measIdx;
      measDist_r <= measDist;
    end

  assign refDist = {1'b0, memBus.rdDataA[15:0]};
  assign tolN    = {9'h0, (memBus.rdDataA[23:16] < 8'(REF_MIN_TOL_MM))
                          ? 8'(REF_MIN_TOL_MM) : memBus.rdDataA[23:16]};
  assign tolF    = {9'h0, (memBus.rdDataA[31:24] < 8'(REF_MIN_TOL_MM))
                          ? 8'(REF_MIN_TOL_MM) : memBus.rdDataA[31:24]};
  assign refEn16 = {1'b0, refEn_r};
  assign refHit  = refOn_r && measV_r && refEn16[measIdx_r];
  assign refDev  = refHit && ((({1'b0, measDist_r} + tolN) < refDist)
                           || ({1'b0, measDist_r} > refDist + tolF));

  genvar p;
  generate
    for (p = 0; p < REF_MAX_POINTS; p++)
    begin : gObj
      assign objHot[p] = refEn_r[p] ? (4'h1 << refObj_r[2*p +: 2]) : 4'h0;
    end
  endgenerate

  // every used object needs three points; 15 is the table size
  always_comb
  begin
    refCfgBad = 1'b0;
    for (int o = 0; o < 4; o++)
    begin
      objCnt[o] = 4'h0;
      for (int k = 0; k < REF_MAX_POINTS; k++)
        objCnt[o] = objCnt[o] + {3'h0, objHot[k][o]};
      if (objCnt[o] != 4'h0 && objCnt[o] < 4'(REF_MIN_PER_OBJ))
        refCfgBad = refOn_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sso_state_e  state_r;
  sso_test_e   tp_r;
  logic [12:0] holdMs_r;
  logic [15:0] recovMs_r;
  logic        pressArmed_r, btnRel, holdValid, validRelease, stopReq, testFail;
  assign stopReq = detStop || secFire || refDev || refCfgBad;
  assign btnRel  = btnPrev_r && !btnSync;
  assign holdValid = holdMs_r >= 13'(HOLD_MIN_MS) && holdMs_r <= 13'(HOLD_MAX_MS);
  // only a press begun in ready with a valid hold counts
  assign validRelease = btnRel && holdValid && pressArmed_r;

  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      holdMs_r     <= 13'h0;
      pressArmed_r <= 1'b0;
      recovMs_r    <= 16'h0;
    end
    else
    begin
      if (!btnSync)
        holdMs_r <= 13'h0;
      else if (msTick && holdMs_r <= 13'(HOLD_MAX_MS))
        holdMs_r <= holdMs_r + 13'h1;
      if (state_r != ST_READY || btnRel)
        pressArmed_r <= 1'b0;
      else if (btnSync && !btnPrev_r)
        pressArmed_r <= 1'b1;
      if (state_r != ST_READY || (scanTick && objDetect))
        recovMs_r <= 16'h0;
      else if (msTick && recovMs_r != 16'hffff)
        recovMs_r <= recovMs_r + 16'h1;
    end

  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
      state_r <= ST_BLOCKED;
    else if (testFail)
      state_r <= ST_FAULT;
    else
      case (state_r)
        ST_GO:
          if (stopReq)
            state_r <= ST_BLOCKED;
        ST_BLOCKED:
          if (!zoneOcc_r && !stopReq)
            state_r <= ST_READY;
        ST_READY:
          if (stopReq || zoneOcc_r)
            state_r <= ST_BLOCKED;
          // manual: go only on release; automatic after recovery
          else if (manualMode_r ? validRelease : recovMs_r >= recovEff)
            state_r <= ST_GO;
        ST_FAULT:
          if (faultClr)
            state_r <= ST_BLOCKED;
        default:
          state_r <= ST_BLOCKED;
      endcase

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]  testMs_r;
  logic [13:0] testCnt_r;
  logic        testEnd, testFault_r, wireFault_r, failA, failB;
  assign testEnd = tp_r != TP_IDLE && testCnt_r == 14'(TEST_CYC - 1);
  // pulsed output must read back low
  assign failA = (tp_r == TP_A) ? rbA : rbB;
  // the other output must stay high, else outputs are tied
  assign failB = (tp_r == TP_A) ? !rbB : !rbA;
  assign testFail = testEnd && state_r == ST_GO && (failA || failB);

  // periodic staggered off pulses while on
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      tp_r      <= TP_IDLE;
      testMs_r  <= 7'h0;
      testCnt_r <= 14'h0;
    end
    else if (state_r != ST_GO)
    begin
      tp_r      <= TP_IDLE;
      testMs_r  <= 7'h0;
      testCnt_r <= 14'h0;
    end
    else
    begin
      testCnt_r <= (tp_r == TP_IDLE || testEnd) ? 14'h0 : testCnt_r + 14'h1;
      if (tp_r == TP_IDLE && msTick)
        testMs_r <= testMs_r + 7'h1;
      if (tp_r == TP_IDLE && testMs_r == 7'(TEST_PERIOD_MS))
      begin
        tp_r     <= TP_A;
        testMs_r <= 7'h0;
      end
      else if (testEnd)
        tp_r <= (tp_r == TP_A) ? TP_B : TP_IDLE;
    end

  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      testFault_r <= 1'b0;
      wireFault_r <= 1'b0;
    end
    else
    begin
      testFault_r <= (testFail && failA) || (testFault_r && !faultClr);
      wireFault_r <= (testFail && failB) || (wireFault_r && !faultClr);
    end

  // two separate channels, each drops on any stop
  always_ff @(posedge core_clk or negedge rstN)
    if (!rstN)
    begin
      safeOutA <= 1'b0;
      safeOutB <= 1'b0;
    end
    else
    begin
      safeOutA <= state_r == ST_GO && !stopReq && !testFail && tp_r != TP_A;
      safeOutB <= state_r == ST_GO && !stopReq && !testFail && tp_r != TP_B;
    end

  assign lampOut  = state_r == ST_READY;
  assign faultOut = state_r == ST_FAULT;

  // response readout 62 + 30 per extra scan + 10 per secondary
  assign status = {6'h0,
                   10'(MIN_RESP_MS + SCAN_PERIOD_MS * (int'(scansEff) - MIN_SCANS)
                       + SEC_LAT_MS * int'(secCnt_r)),
                   7'h0, zoneOcc_r, wireFault_r, testFault_r, refCfgBad,
                   faultOut, state_r == ST_BLOCKED, lampOut, safeOutB, safeOutA};

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  sequence sValidRel;
    manualMode_r && state_r == ST_READY && validRelease && !stopReq && !zoneOcc_r;
  endsequence
  sequence sGoOn;
    state_r == ST_GO ##1 (safeOutB || $past(stopReq));
  endsequence

  AST_DET_STOP: assert property (detStop |=> !safeOutA && !safeOutB)
    else $error("outputs not off after detection");
  AST_AUTO_WAIT: assert property (!manualMode_r && state_r == ST_READY
    && recovMs_r < recovEff |=> state_r != ST_GO)
    else $error("auto restart before recovery time");
  AST_MAN_GO: assert property (sValidRel |=> sGoOn)
    else $error("valid release did not restart");
  AST_NO_PRESS_GO: assert property (manualMode_r && state_r != ST_GO && btnSync
    |=> state_r != ST_GO)
    else $error("restart on press instead of release");
  AST_SHORT_PRESS: assert property (btnRel && holdMs_r < 13'(HOLD_MIN_MS)
    && manualMode_r && state_r != ST_GO |=> state_r != ST_GO)
    else $error("short press accepted");
  AST_BLOCK_STAY: assert property (state_r == ST_BLOCKED && zoneOcc_r
    |=> state_r inside {ST_BLOCKED, ST_FAULT})
    else $error("left blocked while occupied");
  AST_LAMP_OFF: assert property (lampOut |-> !safeOutA && !safeOutB)
    else $error("lamp lit with outputs on");
  AST_TEST_FAULT: assert property (testFail |=> faultOut ##1 (!safeOutA && !safeOutB))
    else $error("readback failure not faulted");
  AST_REF_DEV: assert property (refDev |=> !safeOutA && !safeOutB)
    else $error("reference deviation kept outputs on");
  AST_SEC_LAT: assert property (secRise && secCnt_r != 2'h0 && !latRun_r
    |-> !secFire ##1 !secFire)
    else $error("secondary stop without latency");
  AST_TEST_PULSE: assert property (state_r == ST_GO && tp_r == TP_A && !$past(testFail)
    |=> !safeOutA)
    else $error("test pulse not applied");
endmodule
`default_nettype wire

// ---- tb/sso_machine_model.sv ----
// Purpose: machine side dual channel input and restart push-button
// Assumes: core_clk domain, readback lags outputs by two cycles
// Notes:   stuckA holds channel A readback high to provoke a test fault
`timescale 1ns/1ps
`default_nettype none
module sso_machine_model
#(
  parameter int CYC_MS = 50
)(
  input  wire logic core_clk,
  input  wire logic safeOutA,
  input  wire logic safeOutB,
  input  wire logic stuckA,
  output logic      readbackA,
  output logic      readbackB,
  output logic      restartBtn
);
  logic [1:0] dlyA;
  logic [1:0] dlyB;
  initial restartBtn = 1'b0;
  always_ff @(posedge core_clk)
  begin
    dlyA <= {dlyA[0], safeOutA};
    dlyB <= {dlyB[0], safeOutB};
  end
  assign readbackA = stuckA | dlyA[1];
  assign readbackB = dlyB[1];
  task automatic press(input int ms);
    @(posedge core_clk);
    restartBtn <= 1'b1;
    repeat (ms * CYC_MS) @(posedge core_clk);
    restartBtn <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/safety_output_restart_control_tb_top.sv ----
// Purpose: self-checking bench for the safety output restart block
// Assumes: 1 ms shortened to 50 cycles, test pulse to 20 cycles
// Notes:   bus tasks follow single word AHB-Lite transfers
`timescale 1ns/1ps
`default_nettype none
module safety_output_restart_control_tb_top;
  import sso_pkg::*;
  localparam int MS   = 50;
  localparam int SCAN = 30 * MS;
  logic core_clk = 1'b0, rst_n, hsel, hwrite, hreadyout, hresp, objDetect, stuckA;
  logic secStop, measValid, restartBtn, readbackA, readbackB;
  logic safeOutA, safeOutB, lampOut, faultOut;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  measIdx;
  logic [15:0] measDist;
  int          errors = 0, check_count = 0, c;
  always #10 core_clk = ~core_clk;
  sso_restart_ctrl #(.CYC_MS(MS), .TEST_CYC(20)) sso_restart_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .objDetect(objDetect), .secStop(secStop),
    .measValid(measValid), .measIdx(measIdx), .measDist(measDist), .restartBtn(restartBtn),
    .readbackA(readbackA), .readbackB(readbackB), .safeOutA(safeOutA), .safeOutB(safeOutB),
    .lampOut(lampOut), .faultOut(faultOut));
  sso_machine_model #(.CYC_MS(MS)) sso_machine_model_inst (.core_clk(core_clk),
    .safeOutA(safeOutA), .safeOutB(safeOutB), .stuckA(stuckA), .readbackA(readbackA),
    .readbackB(readbackB), .restartBtn(restartBtn));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  function automatic logic pick(input int sel);
    return (sel == 0) ? safeOutA : (sel == 1) ? lampOut : faultOut;
  endfunction
  // waits bounded; the final compare flags a timeout
  task automatic waitSig(input int sel, input logic v, input int maxMs);
    c = 0;
    while (pick(sel) !== v && c < maxMs * MS)
    begin
      @(posedge core_clk);
      c++;
    end
    chk(pick(sel), v);
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge core_clk);
    errors++;
    summarize();
  end
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    objDetect = 1'b0;
    stuckA = 1'b0;
    secStop = 1'b0;
    measValid = 1'b0;
    measIdx = 4'hf;
    measDist = 16'h0000;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(safeOutA, 1'b0);
    bus(1'b0, 32'h0, 32'h0);
    chk(d, 32'h4);
    bus(1'b0, 32'h4, 32'h0);
    chk(d, 32'hc8);
    bus(1'b0, 32'h3c, 32'h0);
    chk(d, 32'h0);
    waitSig(0, 1'b1, 300);
    chk(safeOutB, 1'b1);
    // one secondary unit delays its stop by 10 ms
    bus(1'b1, 32'h0, 32'h44);
    secStop <= 1'b1;
    waitSig(0, 1'b0, 20);
    chk(c >= 9 * MS && c <= 11 * MS, 1'b1);
    chk(safeOutB, 1'b0);
    secStop <= 1'b0;
    waitSig(0, 1'b1, 300);
    // detection needs two confirming scans
    objDetect <= 1'b1;
    waitSig(0, 1'b0, 100);
    chk(safeOutB, 1'b0);
    chk(c >= SCAN && c <= 3 * SCAN + 10, 1'b1);
    objDetect <= 1'b0;
    waitSig(0, 1'b1, 300);
    chk(c >= 199 * MS && c <= 232 * MS, 1'b1);
    bus(1'b1, 32'h0, 32'h5);
    objDetect <= 1'b1;
    waitSig(0, 1'b0, 100);
    sso_machine_model_inst.press(505);
    repeat (10) @(posedge core_clk);
    chk(safeOutA, 1'b0);
    chk(lampOut, 1'b0);
    objDetect <= 1'b0;
    waitSig(1, 1'b1, 60);
    sso_machine_model_inst.press(50);
    repeat (10 * MS) @(posedge core_clk);
    chk(safeOutA, 1'b0);
    chk(lampOut, 1'b1);
    sso_machine_model_inst.press(505);
    chk(safeOutA, 1'b0);
    waitSig(0, 1'b1, 1);
    chk(safeOutB, 1'b1);
    // stuck readback during self test must trip the fault
    stuckA <= 1'b1;
    waitSig(2, 1'b1, 150);
    chk({safeOutA, safeOutB}, 2'b00);
    stuckA <= 1'b0;
    bus(1'b1, 32'h0, 32'h205);
    bus(1'b0, 32'h8, 32'h0);
    chk(d[4], 1'b0);
    // point 0 at 1000 mm, tolerances written as zero
    bus(1'b1, 32'h40, 32'h3e8);
    bus(1'b0, 32'h40, 32'h0);
    chk(d, 32'h3e8);
    bus(1'b1, 32'hc, 32'h3);
    bus(1'b1, 32'h0, 32'h18b);
    bus(1'b0, 32'h0, 32'h0);
    chk(d, 32'h18b);
    bus(1'b0, 32'h8, 32'h0);
    chk(d[25:16], 10'hac);
    chk(d[5], 1'b1);
    bus(1'b1, 32'hc, 32'h7);
    // 20 mm short of the point is outside the 10 mm floor
    measIdx <= 4'h0;
    measDist <= 16'h03d4;
    measValid <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(lampOut, 1'b0);
    measDist <= 16'h03f1;
    repeat (5) @(posedge core_clk);
    chk(lampOut, 1'b1);
    measValid <= 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
